// ---- rtl/cfbt_flash_timing.sv ----
/*
  Flash area bus timing controller with AXI4-Lite registers.
  Assumes an asynchronous NOR flash on the pins and a width strap
  that is held static from power-on.
*/
// Our own choice: the AXI4-Lite register port.
`default_nettype none
module cfbt_flash_timing
  import cfbt_pkg::*;
#(
  parameter int FLASH_AW = 22
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // AXI4-Lite slave
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Flash pins
  output logic                     busClockOut,
  output logic                     flashAreaSelectN,
  output logic                     readStrobeN,
  output logic                     writeStrobeN,
  output logic [FLASH_AW-1:0]      flashAddr,
  output logic [31:0]              flashDataOut,
  output logic                     flashDataOe,
  input  wire logic [31:0]         flashDataIn,
  input  wire logic                extWaitN,
  input  wire logic                widthStrapPin
);
  typedef struct packed {
    cfbt_state_t       st;
    logic [3:0]        cnt;
    logic              busClk;
    logic              csN;
    logic              rdN;
    logic              wrN;
    logic [FLASH_AW-1:0] addr;
    logic [31:0]       dOut;
    logic              dOe;
    logic [31:0]       busCtrl;
    logic [31:0]       waitCtrl;
    logic [31:0]       accAddr;
    logic [31:0]       accData;
    logic              pend;
    logic              isWr;
    logic              xArea;
    logic              lastWr;
    logic [2:0]        wSync;
    logic              wFilt;
    logic [2:0]        sSync;
    logic [1:0]        sCnt;
    logic              strapDone;
    logic              w32;
    logic [31:0]       awAddr;
    logic              awHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              wHave;
    logic              awRdy;
    logic              wRdy;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
  } cfbt_regs_t;

  cfbt_regs_t s, n;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  logic [2:0] idleWr, idleXArea, idleSArea, gap;
  logic [1:0] leadSel, trailSel;
  logic [3:0] wr;
  logic       waitMask, tick, busy, waitAct;
  assign idleWr    = s.busCtrl[IDLE_WR_LSB +: 3];
  assign idleXArea = s.busCtrl[IDLE_XAREA_LSB +: 3];
  assign idleSArea = s.busCtrl[IDLE_SAREA_LSB +: 3];
  assign leadSel   = s.waitCtrl[LEAD_LSB +: 2];
  assign trailSel  = s.waitCtrl[TRAIL_LSB +: 2];
  assign wr        = s.waitCtrl[WR_LSB +: 4];
  assign waitMask  = s.waitCtrl[WMASK_BIT];
  // Bus clock rises at this edge
  assign tick    = !s.busClk;
  assign busy    = s.pend || (s.st != ST_IDLE);
  assign waitAct = !s.wFilt;

  always_comb begin
    n = s;
    n.busClk = !s.busClk;
    // Pin synchronisers, change taken when stages 2 and 3 agree
    n.wSync = {s.wSync[1:0], extWaitN};
    if (s.wSync[1] == s.wSync[2]) begin
      n.wFilt = s.wSync[2];
    end
    n.sSync = {s.sSync[1:0], widthStrapPin};
    if (s.sCnt != STRAP_FILL) begin
      n.sCnt = s.sCnt + 2'h1;
    end else if (!s.strapDone && s.sSync[1] == s.sSync[2]) begin
      n.w32       = s.sSync[2];
      n.strapDone = 1'b1;
    end
    // Gap chooser
    if (s.lastWr) begin
      gap = idleWr;
    end else if (s.isWr && s.xArea) begin
      gap = idleXArea;
    end else if (s.isWr) begin
      gap = idleSArea;
    end else begin
      gap = 3'h0;
    end
    if (tick) begin
      case (s.st)
        ST_IDLE: begin
          if (s.pend && s.strapDone) begin
            if (gap != 3'h0) begin
              n.st  = ST_GAP;
              n.cnt = {1'b0, gap - 3'h1};
            end else begin
              n.st = ST_LEAD;
              n.cnt = 4'h0;
              n.pend = 1'b0;
            end
          end
        end
        ST_GAP: begin
          if (s.cnt == 4'h0) begin
            n.st   = ST_LEAD;
            n.pend = 1'b0;
          end else begin
            n.cnt = s.cnt - 4'h1;
          end
        end
        ST_LEAD: begin
          // Lead countdown is handled after the case
        end
        ST_FIRST: begin
          if (wr == 4'h0) begin
            n.st = ST_FINAL;
          end else begin
            n.st  = ST_WAIT;
            n.cnt = wr - 4'h1;
          end
        end
        ST_WAIT: begin
          if (s.cnt != 4'h0) begin
            n.cnt = s.cnt - 4'h1;
          end else if (!(!waitMask && waitAct)) begin
            n.st = ST_FINAL;
          end
        end
        ST_FINAL: begin
          n.rdN = 1'b1;
          n.wrN = 1'b1;
          if (!s.isWr) begin
            n.accData = s.w32 ? flashDataIn
                              : {16'h0000, flashDataIn[15:0]};
          end
          if (trailSel == 2'h0) begin
            n.st = ST_IDLE;
            n.csN = 1'b1;
            n.dOe = 1'b0;
            n.lastWr = s.isWr;
          end else begin
            n.st  = ST_TRAIL;
            n.cnt = {2'h0, trailSel - 2'h1};
          end
        end
        ST_TRAIL: begin
          if (s.cnt == 4'h0) begin
            n.st  = ST_IDLE;
            n.csN = 1'b1;
            n.dOe = 1'b0;
            n.lastWr = s.isWr;
          end else begin
            n.cnt = s.cnt - 4'h1;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
      // Access start: select and address, strobe after lead (same edge as select when leadSel is 0)
      if (n.st == ST_LEAD && s.st != ST_LEAD) begin
        n.csN  = 1'b0;
        n.addr = s.accAddr[FLASH_AW-1:0];
        n.dOe  = s.isWr;
        n.dOut = s.w32 ? s.accData : {16'h0000, s.accData[15:0]};
        n.cnt  = {2'h0, leadSel};
      end
      if (n.st == ST_LEAD) begin
        if (n.cnt == 4'h0) begin
          n.st  = ST_FIRST;
          n.rdN = s.isWr;
          n.wrN = !s.isWr;
        end else begin
          n.cnt = n.cnt - 4'h1;
        end
      end
    end
    // AXI write channel
    if (s.awRdy && s_axi_awvalid) begin
      n.awAddr = s_axi_awaddr;
      n.awHave = 1'b1;
    end
    if (s.wRdy && s_axi_wvalid) begin
      n.wData  = s_axi_wdata;
      n.wStrb  = s_axi_wstrb;
      n.wHave  = 1'b1;
    end
    if (s.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = RESP_OKAY;
      case (s.awAddr)
        BUS_CTRL_ADDR: n.busCtrl = (mergeBytes(s.busCtrl, s.wData,
          s.wStrb) & BUS_CTRL_WMASK) | (s.busCtrl & ~BUS_CTRL_WMASK);
        WAIT_CTRL_ADDR: n.waitCtrl = (mergeBytes(s.waitCtrl, s.wData,
          s.wStrb) & WAIT_CTRL_WMASK) | (s.waitCtrl & ~WAIT_CTRL_WMASK);
        ACC_ADDR_ADDR: n.accAddr = mergeBytes(s.accAddr, s.wData, s.wStrb);
        ACC_DATA_ADDR: begin
          if (!busy) begin
            n.accData = mergeBytes(s.accData, s.wData, s.wStrb);
          end
        end
        ACC_CTRL_ADDR: begin
          if (!busy && s.wStrb[0] && s.wData[CTRL_GO_BIT]) begin
            n.pend  = 1'b1;
            n.isWr  = s.wData[CTRL_WR_BIT];
            n.xArea = s.wData[CTRL_XAREA_BIT];
          end
        end
        STATUS_ADDR: begin
        end
        default: n.bResp = RESP_DECERR;
      endcase
    end
    n.awRdy = !n.awHave && !n.bValid;
    n.wRdy  = !n.wHave && !n.bValid;
    // AXI read channel
    if (s.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
    end
    if (s.arRdy && s_axi_arvalid) begin
      n.rValid = 1'b1;
      n.rResp  = RESP_OKAY;
      n.rData  = 32'h00000000;
      case (s_axi_araddr)
        BUS_CTRL_ADDR: begin
          n.rData = s.busCtrl;
          n.rData[WIDTH_LSB +: 2] = s.w32 ? WIDTH_32 : WIDTH_16;
        end
        WAIT_CTRL_ADDR: n.rData = s.waitCtrl;
        ACC_ADDR_ADDR:  n.rData = s.accAddr;
        ACC_DATA_ADDR:  n.rData = s.accData;
        ACC_CTRL_ADDR:  n.rData = 32'h00000000;
        STATUS_ADDR: begin
          n.rData[STAT_BUSY_BIT] = busy;
          n.rData[STAT_W32_BIT]  = s.w32;
        end
        default: n.rResp = RESP_DECERR;
      endcase
    end
    n.arRdy = !n.rValid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.csN      <= 1'b1;
      s.rdN      <= 1'b1;
      s.wrN      <= 1'b1;
      s.busCtrl  <= BUS_CTRL_RST;
      s.waitCtrl <= WAIT_CTRL_RST;
      s.wSync    <= 3'h7;
      s.wFilt    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready    = s.awRdy;
  assign s_axi_wready     = s.wRdy;
  assign s_axi_bresp      = s.bResp;
  assign s_axi_bvalid     = s.bValid;
  assign s_axi_arready    = s.arRdy;
  assign s_axi_rdata      = s.rData;
  assign s_axi_rresp      = s.rResp;
  assign s_axi_rvalid     = s.rValid;
  assign busClockOut      = s.busClk;
  assign flashAreaSelectN = s.csN;
  assign readStrobeN      = s.rdN;
  assign writeStrobeN     = s.wrN;
  assign flashAddr        = s.addr;
  assign flashDataOut     = s.dOut;
  assign flashDataOe      = s.dOe;

  logic stbN;
  assign stbN = s.rdN && s.wrN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_idleAfterWrite;
    $rose(s.csN) && s.isWr && idleWr != 3'h0 |-> s.csN [*4];
  endproperty
  a_idleAfterWrite: assert property (p_idleAfterWrite)
    else $error("write gap too short");
  property p_widthFixed;
    s.strapDone |=> $stable(s.w32) && s.busCtrl[WIDTH_LSB +: 2] == 2'h0;
  endproperty
  a_widthFixed: assert property (p_widthFixed)
    else $error("width changed after strap");
  property p_lead15;
    $fell(s.csN) && leadSel == 2'h1 |-> stbN [*2] ##1 !stbN;
  endproperty
  a_lead15: assert property (p_lead15)
    else $error("lead delay wrong");
  property p_lead05;
    $fell(s.csN) && leadSel == 2'h0 |-> !stbN;
  endproperty
  a_lead05: assert property (p_lead05)
    else $error("half cycle lead wrong");
  property p_wait4;
    $fell(stbN) && wr == 4'h4 && waitMask |-> ##11 !stbN ##1 stbN;
  endproperty
  a_wait4: assert property (p_wait4)
    else $error("strobe width wrong");
  property p_trail15;
    $rose(stbN) && trailSel == 2'h1 |-> !s.csN [*2] ##1 s.csN;
  endproperty
  a_trail15: assert property (p_trail15)
    else $error("trail delay wrong");
  property p_launch;
    $changed(s.csN) || $changed(stbN) |-> s.busClk;
  endproperty
  a_launch: assert property (p_launch)
    else $error("pin moved off clock rise");
  property p_writeWindow;
    !s.wrN |-> !s.csN && s.rdN && s.dOe;
  endproperty
  a_writeWindow: assert property (p_writeWindow)
    else $error("write strobe outside select");
  property p_readWindow;
    !s.rdN |-> !s.csN && !s.dOe;
  endproperty
  a_readWindow: assert property (p_readWindow)
    else $error("read strobe outside select");
  property p_extWait;
    s.st == ST_WAIT && s.cnt == 4'h0 && !waitMask && waitAct |=>
      s.st == ST_WAIT;
  endproperty
  a_extWait: assert property (p_extWait)
    else $error("external wait not honoured");

  c_write: cover property ($rose(s.wrN) && !s.csN);
  c_read: cover property ($rose(s.rdN) && !s.isWr);
  c_waitHold: cover property (s.st == ST_WAIT && waitAct && !waitMask);
  c_gap: cover property (s.st == ST_GAP);
endmodule : cfbt_flash_timing
`default_nettype wire

// ---- rtl/cfbt_pkg.sv ----
/*
  Constants for the flash area bus timing block: register map,
  field layout, write masks and FSM states.
  Assumes a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package cfbt_pkg;
  localparam logic [31:0] BUS_CTRL_ADDR  = 32'hFEC10004;
  localparam logic [31:0] WAIT_CTRL_ADDR = 32'hFEC10024;
  localparam logic [31:0] ACC_ADDR_ADDR  = 32'hFEC10100;
  localparam logic [31:0] ACC_DATA_ADDR  = 32'hFEC10104;
  localparam logic [31:0] ACC_CTRL_ADDR  = 32'hFEC10108;
  localparam logic [31:0] STATUS_ADDR    = 32'hFEC1010C;
  localparam int IDLE_WR_LSB    = 28;
  localparam int IDLE_XAREA_LSB = 22;
  localparam int IDLE_SAREA_LSB = 19;
  localparam int WIDTH_LSB      = 9;
  localparam int TRAIL_LSB      = 0;
  localparam int WMASK_BIT      = 6;
  localparam int WR_LSB         = 7;
  localparam int LEAD_LSB       = 11;
  localparam logic [31:0] BUS_CTRL_RST   = 32'h00000000;
  localparam logic [31:0] WAIT_CTRL_RST  = 32'h00000000;
  localparam logic [31:0] BUS_CTRL_WMASK = 32'h71F80000;
  localparam logic [31:0] WAIT_CTRL_WMASK = 32'h00001FC3;
  localparam logic [1:0]  WIDTH_16 = 2'h2;
  localparam logic [1:0]  WIDTH_32 = 2'h3;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_WR_BIT    = 1;
  localparam int CTRL_XAREA_BIT = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_W32_BIT   = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] STRAP_FILL  = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_GAP   = 3'b001,
    ST_LEAD  = 3'b010,
    ST_FIRST = 3'b011,
    ST_WAIT  = 3'b100,
    ST_FINAL = 3'b101,
    ST_TRAIL = 3'b110
  } cfbt_state_t;
endpackage : cfbt_pkg
`default_nettype wire

// ---- testbench/cfbt_flash_model.sv ----
/*
  Behavioural 16-bit NOR flash on the area pins: stores halfwords,
  answers reads, holds wait low on command, times each access phase.
  Assumes the pins change only on rising edges of clk.
*/
`default_nettype none
module cfbt_flash_model (
  // Clock
  input  wire logic        clk,
  // Flash pins
  input  wire logic        selN,
  input  wire logic        rdN,
  input  wire logic        wrN,
  input  wire logic [21:0] addr,
  input  wire logic [31:0] dOut,
  output logic      [31:0] dIn,
  output logic             waitN,
  // Stall length and phase lengths in clocks
  input  wire logic [7:0]  stallClk,
  output logic      [7:0]  idleCnt,
  output logic      [7:0]  leadCnt,
  output logic      [7:0]  pulseCnt,
  output logic      [7:0]  trailCnt
);
  logic [15:0] mem [0:15];
  logic [31:0] lastIn  = 32'h0;
  logic [7:0]  run     = 8'h0;
  logic        prevSel = 1'h1;
  logic        prevStb = 1'h0;
  logic        stb;

  assign stb   = ~(rdN & wrN);
  assign waitN = ~(stb && run < stallClk);
  // Bus not driven reads back a changing pattern
  assign dIn = (!selN && !rdN) ? {~lastIn[31:16], mem[addr[3:0]]} : ~lastIn;

  always @(posedge clk) begin
    lastIn  <= dIn;
    prevSel <= selN;
    prevStb <= stb;
    run     <= (selN != prevSel || stb != prevStb) ? 8'h1 : run + 8'h1;
    if (!wrN && !selN)
      mem[addr[3:0]] <= dOut[15:0];
    if (!selN && prevSel) begin
      idleCnt <= run;
      if (stb)
        leadCnt <= 8'h0;
    end else if (stb && !prevStb)
      leadCnt <= run;
    if (!stb && prevStb)
      pulseCnt <= run;
    if (selN && !prevSel)
      trailCnt <= (!stb && prevStb) ? 8'h0 : run;
  end
endmodule : cfbt_flash_model
`default_nettype wire

// ---- testbench/cfbt_flash_timing_tb.sv ----
/*
  Self-checking bench for the flash area timing block: registers over
  AXI4-Lite, access phase timing, idle gaps and the wait input.
  Assumes the flash model beside it; width strap held at 16-bit until testStrap drives it high.
*/
`default_nettype none
module cfbt_flash_timing_tb
  import cfbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [31:0] awAddr = '0, wData = '0, arAddr = '0;
  logic        awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
  logic        arValid = 1'h0, rReady = 1'h0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, resp;
  logic [31:0] rData, dOut, dIn, rdVal;
  logic        busClk, selN, rdN, wrN, dOe, waitN;
  logic        strap = 1'h0;
  logic [21:0] fAddr;
  logic [7:0]  stall = 8'h0, idleCnt, leadCnt, pulseCnt, trailCnt;
  logic [2:0]  pinsQ;
  int          fails = 0, num_checks = 0;

  always #10 clk = ~clk;

  cfbt_flash_timing #(.FLASH_AW(22)) dut_u (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .busClockOut(busClk), .flashAreaSelectN(selN), .readStrobeN(rdN),
    .writeStrobeN(wrN), .flashAddr(fAddr), .flashDataOut(dOut),
    .flashDataOe(dOe), .flashDataIn(dIn), .extWaitN(waitN),
    .widthStrapPin(strap)
  );

  cfbt_flash_model flash_u (
    .clk(clk), .selN(selN), .rdN(rdN), .wrN(wrN), .addr(fAddr),
    .dOut(dOut), .dIn(dIn), .waitN(waitN), .stallClk(stall),
    .idleCnt(idleCnt), .leadCnt(leadCnt), .pulseCnt(pulseCnt),
    .trailCnt(trailCnt)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
    logic gotA, gotW;
    gotA = 1'h0;
    gotW = 1'h0;
    @(posedge clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'h1;
    wValid  <= 1'h1;
    bReady  <= 1'h1;
    while (!(gotA && gotW)) begin
      @(posedge clk);
      if (awValid && awReady) begin
        gotA = 1'h1;
        awValid <= 1'h0;
      end
      if (wValid && wReady) begin
        gotW = 1'h1;
        wValid <= 1'h0;
      end
    end
    do @(posedge clk); while (bValid !== 1'h1);
    resp = bResp;
    bReady <= 1'h0;
  endtask : axiWr

  task automatic axiRd(input logic [31:0] a);
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'h1;
    rReady  <= 1'h1;
    do @(posedge clk); while (arReady !== 1'h1);
    arValid <= 1'h0;
    do @(posedge clk); while (rValid !== 1'h1);
    rdVal = rData;
    resp  = rResp;
    rReady <= 1'h0;
  endtask : axiRd

  // Start a flash access and poll until it is over
  task automatic flashGo(input logic wr, input logic xa);
    axiWr(ACC_CTRL_ADDR, {29'h0, xa, wr, 1'h1});
    do axiRd(STATUS_ADDR); while (rdVal[STAT_BUSY_BIT] !== 1'h0);
  endtask : flashGo

  task automatic access(input logic wr, input logic xa,
                        input logic [31:0] a, input logic [31:0] d);
    axiWr(ACC_ADDR_ADDR, a);
    axiWr(ACC_DATA_ADDR, d);
    flashGo(wr, xa);
  endtask : access

  task automatic testRegs;
    axiRd(BUS_CTRL_ADDR);
    check(rdVal, 32'h00000400);
    axiRd(WAIT_CTRL_ADDR);
    check(rdVal, 32'h00000000);
    axiWr(BUS_CTRL_ADDR, 32'hFFFFFFFF);
    axiRd(BUS_CTRL_ADDR);
    check(rdVal, 32'h71F80400);
    axiWr(BUS_CTRL_ADDR, 32'h10480600);
    axiRd(BUS_CTRL_ADDR);
    check(rdVal, 32'h10480400);
    axiWr(WAIT_CTRL_ADDR, 32'h00000A41);
    axiRd(WAIT_CTRL_ADDR);
    check(rdVal, 32'h00000A41);
    axiWr(32'hFEC10008, 32'h00000001);
    check({30'h0, resp}, {30'h0, RESP_DECERR});
    axiRd(32'hFEC10008);
    check({30'h0, resp}, {30'h0, RESP_DECERR});
    check(rdVal, 32'h00000000);
  endtask : testRegs

  // Every lead and trail code, wait counts 1 to 4, then read back
  task automatic testTiming;
    for (int i = 0; i < 4; i++) begin
      axiWr(WAIT_CTRL_ADDR, 32'((i << 11) | ((i + 1) << 7) | 64 | (3 - i)));
      access(1'h1, 1'h0, 32'(i), 32'hFFFFC3A0 + 32'(i));
      check(32'(leadCnt), 32'(2 * i));
      check(32'(pulseCnt), 32'(2 * i + 6));
      check(32'(trailCnt), 32'(6 - 2 * i));
    end
    axiWr(WAIT_CTRL_ADDR, 32'h00000A41);
    for (int i = 0; i < 4; i++) begin
      access(1'h0, 1'h0, 32'(i), 32'h0);
      check(32'(pulseCnt), 32'h0000000C);
      axiRd(ACC_DATA_ADDR);
      check(rdVal, 32'h0000C3A0 + 32'(i));
    end
  endtask : testTiming

  // Largest idle count in one field at a time
  task automatic testGaps;
    int sh [3] = '{IDLE_WR_LSB, IDLE_XAREA_LSB, IDLE_SAREA_LSB};
    for (int k = 0; k < 3; k++) begin
      axiWr(BUS_CTRL_ADDR, 32'h7 << sh[k]);
      access(k == 0, 1'h0, 32'h0, 32'h0);
      flashGo(1'h1, k == 1);
      check(32'(idleCnt >= 8'h10), 32'h1);
    end
  endtask : testGaps

  task automatic testWait;
    axiWr(WAIT_CTRL_ADDR, 32'h00000A01);
    stall <= 8'h14;
    access(1'h1, 1'h0, 32'h0, 32'h0);
    check(32'(pulseCnt >= 8'h14), 32'h1);
    axiWr(WAIT_CTRL_ADDR, 32'h00000A41);
    access(1'h1, 1'h0, 32'h0, 32'h0);
    check(32'(pulseCnt), 32'h0000000C);
    stall <= 8'h0;
  endtask : testWait

  // Second reset with the strap high: 32-bit width taken
  task automatic testStrap;
    @(posedge clk);
    rst   <= 1'h1;
    strap <= 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    axiRd(BUS_CTRL_ADDR);
    check(rdVal, 32'h00000600);
    axiRd(STATUS_ADDR);
    check(rdVal, 32'h00000002);
  endtask : testStrap

  // Pin changes only after a rising bus clock; writes inside select
  always @(negedge clk) begin
    if (!rst && {selN, rdN, wrN} !== pinsQ)
      check({31'h0, busClk}, 32'h1);
    if (!rst && !wrN)
      check({30'h0, selN, dOe}, 32'h1);
    pinsQ = {selN, rdN, wrN};
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    testRegs;
    testTiming;
    testGaps;
    testWait;
    testStrap;
    stop_test;
  end

  // Far beyond the thousand or so cycles the run needs
  initial begin
    #400000;
    fails++;
    stop_test;
  end
endmodule : cfbt_flash_timing_tb
`default_nettype wire
